// ### hw/mnpi_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module mnpi_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } mnpi_fifo_state_type;

    mnpi_fifo_state_type s_reg;
    mnpi_fifo_state_type s_next;
    logic push;
    logic pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("mnpi_fifo: DEPTH must be a power of two, WIDTH positive");
    end

    assign in_ready = s_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid = s_reg.cnt != '0;
    assign out_data = s_reg.mem[s_reg.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr] = in_data;
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (pop) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // mnpi_fifo

// ### hw/mnpi_pkg.sv
// Constants, types and the CRC step of the MII nibble interface
package mnpi_pkg;
    localparam int SYS_CLK_MHZ = 100;
    localparam int TX_CLK_TIMEOUT_NS = 1000;
    localparam int TX_CLK_TIMEOUT_CYC =
        (TX_CLK_TIMEOUT_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int TMO_W = $clog2(TX_CLK_TIMEOUT_CYC + 1);
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TX_CLK_TIMEOUT_CYC - 1);
    localparam int INT_NIBBLE_NS = 40;
    localparam int INT_NIBBLE_CYC = (INT_NIBBLE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int DIV_W = $clog2(INT_NIBBLE_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_NIBBLE_CYC - 1);
    localparam logic [3:0] PREAMBLE_NIB = 4'h5;
    localparam logic [3:0] SFD_NIB = 4'hD;
    localparam logic [3:0] TX_NIB_IDLE = 4'h0;
    localparam logic [3:0] PRE_SFD_CNT = 4'hF;
    localparam logic [3:0] CRC_LAST_CNT = 4'h7;
    localparam logic [7:0] MII_SFD_PATTERN = 8'h5D;
    localparam logic [7:0] SERIAL_SFD_PATTERN = 8'hAB;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

    typedef enum logic [2:0] {MNPI_TX_IDLE, MNPI_TX_PRE, MNPI_TX_LO,
        MNPI_TX_HI, MNPI_TX_CRC, MNPI_TX_END} mnpi_tx_state_type;
    typedef enum logic [1:0] {MNPI_RX_IDLE, MNPI_RX_HUNT,
        MNPI_RX_DATA} mnpi_rx_state_type;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mnpi_tx_word_type;
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic bad;
    } mnpi_rx_word_type;
    typedef struct packed {
        logic valid;
        logic crc_error_flag;
        logic alignment_error_flag;
        logic overflow;
    } mnpi_rx_status_type;
    typedef struct packed {
        logic done;
        logic collision;
    } mnpi_tx_status_type;
    typedef struct packed {
        logic tx_clk;
        logic rx_clk;
        logic col;
        logic crs;
        logic rx_dv;
        logic rx_er;
        logic [3:0] rxd;
        logic ser_clk;
        logic ser_dat;
        logic ser_crs;
    } mnpi_link_in_type;

    typedef struct packed {
        logic tx_clk_d;
        logic rx_clk_d;
        logic ser_clk_d;
        logic path_sel;
        logic carrier;
        logic [TMO_W-1:0] tmo_cnt;
        logic clk_missing;
        logic [DIV_W-1:0] div_cnt;
        mnpi_tx_state_type tx_st;
        logic [3:0] tx_cnt;
        logic tx_en;
        logic [3:0] tx_nib;
        logic [31:0] tx_crc;
        mnpi_tx_word_type tx_buf;
        logic tx_buf_full;
        logic tx_ready;
        logic tx_col;
        logic tx_done;
        mnpi_rx_state_type rx_st;
        logic [7:0] rx_hunt;
        logic [3:0] rx_acc;
        logic [2:0] rx_cnt;
        logic rx_half;
        logic [3:0] rx_lo;
        logic [31:0] rx_crc;
        logic rx_err;
        logic rx_ovf;
        logic [7:0] rx_hold;
        logic rx_hold_full;
        logic fifo_wvalid;
        mnpi_rx_word_type fifo_wdata;
        mnpi_rx_status_type rx_stat;
    } mnpi_state_type;

    localparam mnpi_state_type MNPI_STATE_RESET = '{tx_st: MNPI_TX_IDLE,
        rx_st: MNPI_RX_IDLE, clk_missing: 1'b1, default: '0};

    function automatic logic [31:0] mnpi_crc_nibble(input logic [31:0] crc,
                                                    input logic [3:0] nib);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 4; i++) begin
            c = (c[0] ^ nib[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

// ### hw/mnpi_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module mnpi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } mnpi_sync_state_type;

    mnpi_sync_state_type s_reg;
    mnpi_sync_state_type s_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("mnpi_sync: WIDTH must be at least 1");
    end

    always_comb begin
        s_next.meta = async_in;
        s_next.q = s_reg.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.q;
endmodule // mnpi_sync

// ### hw/mnpi_top.sv
// MII nibble transmit and receive interface towards an external PHY
`timescale 1ns/10ps
module mnpi_top
    import mnpi_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic nibble_path_mii_select,
    output logic nibble_path_select_pin,
    input wire logic tx_nibble_clock,
    input wire logic fast_collision_in,
    output logic fast_tx_enable,
    output logic [3:0] tx_nibble_out,
    input wire logic rx_nibble_clock,
    input wire logic rx_data_valid,
    input wire logic rx_error_in,
    input wire logic [3:0] rx_nibble_in,
    input wire logic fast_carrier_sense,
    input wire logic serial_rx_clock,
    input wire logic serial_rx_data,
    input wire logic serial_rx_carrier,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire mnpi_tx_word_type tx_in_word,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output mnpi_rx_word_type rx_out_word,
    output mnpi_rx_status_type rx_status,
    output mnpi_tx_status_type tx_status,
    output logic carrier_envelope,
    output logic tx_clock_missing
);
    mnpi_link_in_type link_raw;
    mnpi_link_in_type link;
    mnpi_state_type s_reg;
    mnpi_state_type s_next;
    logic fifo_in_ready;
    logic tx_rise;
    logic rx_rise;
    logic ser_rise;
    logic int_tick;
    logic tx_pace;
    logic rx_ev;
    logic rx_act;
    logic [7:0] hunt_next;
    logic [7:0] sfd_pattern;
    logic nib_stb;
    logic [3:0] nib_v;
    logic emit_crc;
    logic crc_bad;

    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("mnpi_top: FIFO_DEPTH must be at least 2");
    end

    // Every PHY-side input passes two flip-flops first
    assign link_raw = '{tx_clk: tx_nibble_clock, rx_clk: rx_nibble_clock,
        col: fast_collision_in, crs: fast_carrier_sense,
        rx_dv: rx_data_valid, rx_er: rx_error_in, rxd: rx_nibble_in,
        ser_clk: serial_rx_clock, ser_dat: serial_rx_data,
        ser_crs: serial_rx_carrier};

    mnpi_sync #(
        .WIDTH($bits(mnpi_link_in_type))
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(link_raw),
        .sync_out(link)
    );

    mnpi_fifo #(
        .WIDTH($bits(mnpi_rx_word_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(s_reg.fifo_wvalid),
        .in_ready(fifo_in_ready),
        .in_data(s_reg.fifo_wdata),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_word)
    );

    // Edge finders on the sampled link clocks
    assign tx_rise = link.tx_clk && !s_reg.tx_clk_d;
    assign rx_rise = link.rx_clk && !s_reg.rx_clk_d;
    assign ser_rise = link.ser_clk && !s_reg.ser_clk_d;
    assign int_tick = s_reg.div_cnt == DIV_LAST;
    assign tx_pace = s_reg.clk_missing ? int_tick : tx_rise;

    // Receive source follows the path select
    assign rx_ev = s_reg.path_sel ? rx_rise : ser_rise;
    assign rx_act = s_reg.path_sel ? link.rx_dv : link.ser_crs;
    assign hunt_next = s_reg.path_sel ? {s_reg.rx_hunt[3:0], link.rxd}
                                      : {s_reg.rx_hunt[6:0], link.ser_dat};
    assign sfd_pattern = s_reg.path_sel ? MII_SFD_PATTERN
                                        : SERIAL_SFD_PATTERN;

    always_comb begin
        s_next = s_reg;
        nib_stb = 1'b0;
        nib_v = 4'h0;
        emit_crc = 1'b0;
        crc_bad = 1'b0;
        s_next.tx_clk_d = link.tx_clk;
        s_next.rx_clk_d = link.rx_clk;
        s_next.ser_clk_d = link.ser_clk;
        s_next.path_sel = nibble_path_mii_select;
        s_next.carrier = link.crs;

        // Transmit clock watchdog on the system clock
        if (tx_rise) begin
            s_next.tmo_cnt = '0;
            s_next.clk_missing = 1'b0;
        end else if (s_reg.tmo_cnt == TMO_LAST) begin
            s_next.clk_missing = 1'b1;
        end else begin
            s_next.tmo_cnt = s_reg.tmo_cnt + 1'b1;
        end
        s_next.div_cnt = int_tick ? '0 : s_reg.div_cnt + 1'b1;

        // Transmit
        s_next.tx_done = 1'b0;
        if (s_reg.tx_st != MNPI_TX_IDLE && link.col) begin
            s_next.tx_col = 1'b1;
        end
        if (tx_in_valid && s_reg.tx_ready) begin
            s_next.tx_buf = tx_in_word;
            s_next.tx_buf_full = 1'b1;
        end
        if (tx_pace) begin
            unique case (s_reg.tx_st)
                MNPI_TX_IDLE: begin
                    if (tx_in_valid && !s_reg.carrier) begin
                        s_next.tx_st = MNPI_TX_PRE;
                        s_next.tx_en = 1'b1;
                        s_next.tx_nib = PREAMBLE_NIB;
                        s_next.tx_cnt = 4'h1;
                        s_next.tx_crc = CRC_INIT;
                        s_next.tx_col = 1'b0;
                    end
                end
                MNPI_TX_PRE: begin
                    if (s_reg.tx_cnt == PRE_SFD_CNT) begin
                        s_next.tx_nib = SFD_NIB;
                        s_next.tx_st = MNPI_TX_LO;
                    end else begin
                        s_next.tx_nib = PREAMBLE_NIB;
                        s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                    end
                end
                MNPI_TX_LO: begin
                    if (s_next.tx_buf_full) begin
                        s_next.tx_nib = s_next.tx_buf.data[3:0];
                        s_next.tx_crc = mnpi_crc_nibble(s_reg.tx_crc,
                            s_next.tx_buf.data[3:0]);
                        s_next.tx_st = MNPI_TX_HI;
                    end else begin
                        s_next.tx_cnt = 4'h0;
                        emit_crc = 1'b1;
                    end
                end
                MNPI_TX_HI: begin
                    s_next.tx_nib = s_reg.tx_buf.data[7:4];
                    s_next.tx_crc = mnpi_crc_nibble(s_reg.tx_crc,
                        s_reg.tx_buf.data[7:4]);
                    s_next.tx_buf_full = 1'b0;
                    s_next.tx_cnt = 4'h0;
                    s_next.tx_st = s_reg.tx_buf.last ? MNPI_TX_CRC
                                                     : MNPI_TX_LO;
                end
                MNPI_TX_CRC: begin
                    emit_crc = 1'b1;
                end
                MNPI_TX_END: begin
                    s_next.tx_en = 1'b0;
                    s_next.tx_nib = TX_NIB_IDLE;
                    s_next.tx_st = MNPI_TX_IDLE;
                    s_next.tx_done = 1'b1;
                end
            endcase
            if (emit_crc) begin
                s_next.tx_nib = ~s_reg.tx_crc[3:0];
                s_next.tx_crc = s_reg.tx_crc >> 4;
                if (s_next.tx_cnt == CRC_LAST_CNT) begin
                    s_next.tx_st = MNPI_TX_END;
                end else begin
                    s_next.tx_st = MNPI_TX_CRC;
                    s_next.tx_cnt = s_next.tx_cnt + 4'h1;
                end
            end
        end
        s_next.tx_ready = !s_next.tx_buf_full &&
            (s_next.tx_st == MNPI_TX_PRE || s_next.tx_st == MNPI_TX_LO ||
             s_next.tx_st == MNPI_TX_HI);

        // Receive
        s_next.fifo_wvalid = 1'b0;
        s_next.rx_stat.valid = 1'b0;
        if (s_reg.fifo_wvalid && !fifo_in_ready) begin
            s_next.rx_ovf = 1'b1;
        end
        if (rx_ev) begin
            if (!rx_act) begin
                if (s_reg.rx_st == MNPI_RX_DATA) begin
                    crc_bad = s_reg.rx_crc != CRC_RESIDUE ||
                        s_reg.rx_err;
                    s_next.rx_stat.valid = 1'b1;
                    s_next.rx_stat.crc_error_flag = crc_bad;
                    s_next.rx_stat.alignment_error_flag = crc_bad &&
                        (s_reg.path_sel ? s_reg.rx_cnt[0]
                                        : s_reg.rx_cnt != 3'h0);
                    s_next.rx_stat.overflow = s_next.rx_ovf;
                    if (s_reg.rx_hold_full) begin
                        s_next.fifo_wvalid = 1'b1;
                        s_next.fifo_wdata = '{data: s_reg.rx_hold,
                            last: 1'b1, bad: crc_bad || s_next.rx_ovf};
                    end
                end
                s_next.rx_st = MNPI_RX_IDLE;
            end else begin
                unique case (s_reg.rx_st)
                    MNPI_RX_IDLE: begin
                        s_next.rx_st = MNPI_RX_HUNT;
                        s_next.rx_hunt = hunt_next;
                        s_next.rx_err = 1'b0;
                    end
                    MNPI_RX_HUNT: begin
                        s_next.rx_hunt = hunt_next;
                        if (hunt_next == sfd_pattern) begin
                            s_next.rx_st = MNPI_RX_DATA;
                            s_next.rx_crc = CRC_INIT;
                            s_next.rx_cnt = 3'h0;
                            s_next.rx_half = 1'b0;
                            s_next.rx_ovf = 1'b0;
                            s_next.rx_hold_full = 1'b0;
                        end
                    end
                    MNPI_RX_DATA: begin
                        if (s_reg.path_sel) begin
                            nib_stb = 1'b1;
                            nib_v = link.rxd;
                        end else begin
                            nib_v = {link.ser_dat, s_reg.rx_acc[3:1]};
                            nib_stb = s_reg.rx_cnt[1:0] == 2'b11;
                            s_next.rx_acc = nib_v;
                        end
                        s_next.rx_cnt = s_reg.rx_cnt + 3'h1;
                    end
                endcase
                if (s_reg.path_sel && link.rx_er) begin
                    s_next.rx_err = 1'b1;
                end
            end
        end
        if (nib_stb) begin
            s_next.rx_crc = mnpi_crc_nibble(s_reg.rx_crc, nib_v);
            s_next.rx_half = !s_reg.rx_half;
            if (!s_reg.rx_half) begin
                s_next.rx_lo = nib_v;
            end else begin
                if (s_reg.rx_hold_full) begin
                    s_next.fifo_wvalid = 1'b1;
                    s_next.fifo_wdata = '{data: s_reg.rx_hold, last: 1'b0,
                        bad: 1'b0};
                end
                s_next.rx_hold = {nib_v, s_reg.rx_lo};
                s_next.rx_hold_full = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s_reg <= MNPI_STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign nibble_path_select_pin = s_reg.path_sel;
    assign fast_tx_enable = s_reg.tx_en;
    assign tx_nibble_out = s_reg.tx_nib;
    assign tx_in_ready = s_reg.tx_ready;
    assign rx_status = s_reg.rx_stat;
    assign tx_status = '{done: s_reg.tx_done, collision: s_reg.tx_col};
    assign carrier_envelope = s_reg.carrier;
    assign tx_clock_missing = s_reg.clk_missing;

    default clocking mnpi_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence tx_opens;
        $rose(fast_tx_enable);
    endsequence
    sequence crc_tail;
        s_reg.tx_st == MNPI_TX_END && tx_pace;
    endsequence
    sequence col_held;
        (fast_collision_in && s_reg.tx_st != MNPI_TX_IDLE) [*4];
    endsequence

    path_pin_mirror_a: assert property (
        $past(resetn) |-> nibble_path_select_pin == $past(nibble_path_mii_select))
        else $error("path pin does not follow select bit");
    tx_open_nibble_a: assert property (
        tx_opens |-> tx_nibble_out == PREAMBLE_NIB && $past(tx_pace))
        else $error("enable rose without preamble nibble");
    tx_pace_only_a: assert property (
        ($changed(fast_tx_enable) || $changed(tx_nibble_out)) |->
        $past(tx_pace))
        else $error("transmit outputs moved off a clock edge");
    tx_crc_close_a: assert property (
        crc_tail |=> !fast_tx_enable && tx_status.done)
        else $error("enable not dropped after last CRC nibble");
    col_sync_seen_a: assert property (
        col_held |-> tx_status.collision)
        else $error("held collision not reported");
    rx_err_bad_a: assert property (
        rx_status.valid |-> rx_status.crc_error_flag || !$past(s_reg.rx_err))
        else $error("frame with receive error not failed");
    align_needs_crc_a: assert property (
        (rx_status.valid && rx_status.alignment_error_flag) |->
        rx_status.crc_error_flag)
        else $error("alignment error without CRC error");
    sof_mii_a: assert property (
        (rx_ev && rx_act && s_reg.path_sel && s_reg.rx_st == MNPI_RX_HUNT &&
         hunt_next == MII_SFD_PATTERN) |=> s_reg.rx_st == MNPI_RX_DATA)
        else $error("start pattern not taken");
    clk_timeout_a: assert property (
        (s_reg.tmo_cnt == TMO_LAST && !tx_rise) |=> tx_clock_missing)
        else $error("transmit clock timeout not declared");
endmodule // mnpi_top

// ### testbench/mnpi_phy_model.sv
// PHY partner model: nibble clocks, receive frames, transmit capture
`timescale 1ns/10ps
module mnpi_phy_model (
    input wire logic tx_clk_on,
    output logic tx_nibble_clock,
    output logic rx_nibble_clock,
    output logic rx_data_valid,
    output logic rx_error_in,
    output logic [3:0] rx_nibble_in,
    output logic serial_rx_clock,
    output logic serial_rx_data,
    output logic serial_rx_carrier,
    input wire logic fast_tx_enable,
    input wire logic [3:0] tx_nibble_out
);
    logic [3:0] cap[$];
    initial begin
        tx_nibble_clock = 1'b0;
        rx_nibble_clock = 1'b0;
        rx_data_valid = 1'b0;
        rx_error_in = 1'b0;
        rx_nibble_in = 4'h0;
        serial_rx_clock = 1'b0;
        serial_rx_data = 1'b0;
        serial_rx_carrier = 1'b0;
        forever begin
            #40;
            tx_nibble_clock = tx_clk_on & ~tx_nibble_clock;
        end
    end
    // Transmit nibbles are taken while the enable is high
    always @(posedge tx_nibble_clock) begin
        if (fast_tx_enable === 1'b1) cap.push_back(tx_nibble_out);
    end
    // Sends one frame and one more clock with the valid low; the clock stands still otherwise
    task automatic send(input logic [3:0] n[$], input int er);
        foreach (n[i]) begin
            rx_data_valid = 1'b1;
            rx_error_in = (i == er);
            rx_nibble_in = n[i];
            #40 rx_nibble_clock = 1'b1;
            #40 rx_nibble_clock = 1'b0;
        end
        rx_data_valid = 1'b0;
        rx_error_in = 1'b0;
        rx_nibble_in = ~rx_nibble_in;
        #40 rx_nibble_clock = 1'b1;
        #40 rx_nibble_clock = 1'b0;
    endtask
    // Serial codec frame, one bit per 10 MHz clock, carrier as envelope
    task automatic send_bits(input logic b[$]);
        foreach (b[i]) begin
            serial_rx_carrier = 1'b1;
            serial_rx_data = b[i];
            #50 serial_rx_clock = 1'b1;
            #50 serial_rx_clock = 1'b0;
        end
        serial_rx_carrier = 1'b0;
        serial_rx_data = ~serial_rx_data;
        #50 serial_rx_clock = 1'b1;
        #50 serial_rx_clock = 1'b0;
    endtask
endmodule // mnpi_phy_model

// ### testbench/tb.sv
// Testbench of the MII nibble interface
`timescale 1ns/10ps
module tb
    import mnpi_pkg::*;
();
    logic sys_clk, resetn, nibble_path_mii_select, nibble_path_select_pin;
    logic tx_nibble_clock, fast_collision_in, fast_tx_enable, tx_clk_on;
    logic rx_nibble_clock, rx_data_valid, rx_error_in, fast_carrier_sense;
    logic tx_in_valid, tx_in_ready, rx_out_valid, carrier_envelope;
    logic tx_clock_missing;
    logic serial_rx_clock, serial_rx_data, serial_rx_carrier;
    logic rx_out_ready, last_bad;
    logic [3:0] tx_nibble_out, rx_nibble_in;
    mnpi_tx_word_type tx_in_word;
    mnpi_rx_word_type rx_out_word;
    mnpi_rx_status_type rx_status, last_stat;
    mnpi_tx_status_type tx_status;
    int mismatches, num_checks, ndone, nstat;
    logic [7:0] rxq[$];
    logic [3:0] exq[$];
    mnpi_top dut (.sys_clk, .resetn, .nibble_path_mii_select,
        .nibble_path_select_pin, .tx_nibble_clock, .fast_collision_in,
        .fast_tx_enable, .tx_nibble_out, .rx_nibble_clock, .rx_data_valid,
        .rx_error_in, .rx_nibble_in, .fast_carrier_sense,
        .serial_rx_clock, .serial_rx_data, .serial_rx_carrier,
        .tx_in_valid, .tx_in_ready, .tx_in_word,
        .rx_out_valid, .rx_out_ready, .rx_out_word, .rx_status,
        .tx_status, .carrier_envelope, .tx_clock_missing);
    mnpi_phy_model phy (.tx_clk_on, .tx_nibble_clock, .rx_nibble_clock,
        .rx_data_valid, .rx_error_in, .rx_nibble_in, .serial_rx_clock,
        .serial_rx_data, .serial_rx_carrier, .fast_tx_enable,
        .tx_nibble_out);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (tx_status.done === 1'b1) ndone++;
        if (rx_status.valid === 1'b1) begin
            nstat++;
            last_stat = rx_status;
        end
        if (rx_out_valid === 1'b1) begin
            rxq.push_back(rx_out_word.data);
            if (rx_out_word.last === 1'b1) last_bad = rx_out_word.bad;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_cnt(ref int c, input int t);
        for (int k = 0; k < 3000 && c < t; k++) @(negedge sys_clk);
        if (c < t) begin
            mismatches++;
            final_report();
        end
    endtask
    function automatic logic [31:0] fcs(input logic [3:0] n[$]);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        foreach (n[i])
            for (int b = 0; b < 4; b++)
                c = (c[0] ^ n[i][b]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        return ~c;
    endfunction
    task automatic put_byte(input logic [7:0] d, input logic l);
        int k;
        @(negedge sys_clk);
        tx_in_valid = 1'b1;
        tx_in_word = '{data: d, last: l};
        for (k = 0; k < 3000; k++) begin
            if (tx_in_ready === 1'b1) break;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        tx_in_valid = 1'b0;
        if (k == 3000) begin
            mismatches++;
            final_report();
        end
    endtask
    task automatic tx_frame();
        logic [3:0] d[$];
        logic [31:0] c;
        d = {4'hC, 4'h3, 4'h1, 4'hE};
        c = fcs(d);
        repeat (15) exq.push_back(4'h5);
        exq.push_back(4'hD);
        foreach (d[i]) exq.push_back(d[i]);
        for (int i = 0; i < 8; i++) exq.push_back(c[4*i+:4]);
        fast_carrier_sense = 1'b1;
        repeat (4) @(negedge sys_clk);
        tx_in_valid = 1'b1;
        tx_in_word = '{data: 8'h3C, last: 1'b0};
        repeat (30) @(negedge sys_clk);
        check("deferred enable", fast_tx_enable, 1'b0);
        check("carrier", carrier_envelope, 1'b1);
        fast_carrier_sense = 1'b0;
        fast_collision_in = 1'b1;
        put_byte(8'h3C, 1'b0);
        put_byte(8'hE1, 1'b1);
        fast_collision_in = 1'b0;
        wait_cnt(ndone, 1);
        check("collision", tx_status.collision, 1'b1);
        check("tx count", phy.cap.size(), exq.size());
        foreach (exq[i]) check("tx nibble", phy.cap[i], exq[i]);
    endtask
    task automatic rx_frame(input logic [3:0] dn[$], input int er,
                            input logic bad, input logic odd);
        logic [3:0] q[$];
        logic [31:0] c;
        int n0;
        c = fcs(dn);
        q = {4'h5, 4'hD, dn};
        for (int i = 0; i < 8; i++) q.push_back(c[4*i+:4] ^ {4{odd}});
        n0 = nstat;
        rxq.delete();
        phy.send(q, er);
        wait_cnt(nstat, n0 + 1);
        repeat (4) @(negedge sys_clk);
        check("rx crc flag", last_stat.crc_error_flag, bad);
        check("rx bad word", last_bad, bad);
        check("rx align flag", last_stat.alignment_error_flag, odd);
        check("rx byte0", rxq[0], {dn[1], dn[0]});
    endtask
    task automatic ser_frame();
        logic [3:0] q[$];
        logic b[$];
        logic [31:0] c;
        int n0;
        q = {4'h6, 4'h9, 4'h0, 4'hF};
        c = fcs(q);
        for (int i = 0; i < 8; i++) q.push_back(c[4*i+:4]);
        b = {1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        foreach (q[i])
            for (int k = 0; k < 4; k++) b.push_back(q[i][k]);
        nibble_path_mii_select = 1'b0;
        repeat (4) @(negedge sys_clk);
        n0 = nstat;
        rxq.delete();
        phy.send_bits(b);
        wait_cnt(nstat, n0 + 1);
        repeat (4) @(negedge sys_clk);
        nibble_path_mii_select = 1'b1;
        check("ser crc flag", last_stat.crc_error_flag, 1'b0);
        check("ser align flag", last_stat.alignment_error_flag, 1'b0);
        check("ser byte0", rxq[0], 8'h96);
    endtask
    initial begin
        resetn = 1'b0;
        nibble_path_mii_select = 1'b1;
        fast_collision_in = 1'b0;
        fast_carrier_sense = 1'b0;
        tx_in_valid = 1'b0;
        tx_in_word = '0;
        tx_clk_on = 1'b0;
        rx_out_ready = 1'b1;
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("clock missing", tx_clock_missing, 1'b1);
        nibble_path_mii_select = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("select pin", nibble_path_select_pin, 1'b0);
        nibble_path_mii_select = 1'b1;
        tx_clk_on = 1'b1;
        repeat (40) @(negedge sys_clk);
        check("select pin", nibble_path_select_pin, 1'b1);
        check("clock found", tx_clock_missing, 1'b0);
        tx_frame();
        rx_frame({4'h2, 4'h1, 4'h7, 4'hA}, -1, 1'b0, 1'b0);
        rx_frame({4'h2, 4'h1, 4'h7, 4'hA}, 3, 1'b1, 1'b0);
        rx_frame({4'h2, 4'h1, 4'h7}, -1, 1'b1, 1'b1);
        ser_frame();
        tx_clk_on = 1'b0;
        repeat (150) @(negedge sys_clk);
        check("clock lost", tx_clock_missing, 1'b1);
        final_report();
    end
endmodule // tb
